//--- sef_defs.svh
// Constants of the serial EEPROM front end.
// Operation
// - Hold 128 bytes of storage, one byte each, chosen by host byte address.
// - First byte of each transaction fills an 8-bit instruction register.
// - Sample input on serial clock rising edges only while selected.
// - All bytes travel most significant bit first, both directions.
// - First rising edge after select falls takes bit one, counter fresh.
// - Pause freezes transaction state; release resumes from the same bit.
// - Pause low floats serial output; pause high drives it again.
// - Select rising after a valid write starts a write cycle under 5 ms.
// - Decode instruction bytes with bit 3 ignored per the opcode table.
// - Read streams bytes, address incrementing and wrapping 7Fh to 00h.
// - Write latch set only by full enable byte then select high.
// - Page write wraps low four address bits within the page.
`ifndef SEF_DEFS_SVH
`define SEF_DEFS_SVH
`define EE_DEPTH      128
`define EE_AW         7
`define EE_PAGE_AW    4
`define EE_PAGE_BYTES 16
`define EE_TWC_MS     5
`define EE_CLK_KHZ    125000
`define EE_LAST_BIT   3'h7
`define EE_OP_READ    7'h03
`define EE_OP_WRITE   7'h02
`define EE_OP_CLR_WL  7'h04
`define EE_OP_SET_WL  7'h06
`define EE_OP_SREAD   7'h05
`define EE_OP_SWRITE  7'h01
`define EE_BP_LSB     2
`define EE_PROT_QTR   7'h60
`define EE_PROT_HALF  7'h40
`endif

//--- sef_pkg.sv
// Types shared by the serial EEPROM front end.
package sef_pkg;
    typedef enum logic [2:0] {
        SEF_ST_CMD  = 3'h0,
        SEF_ST_ADDR = 3'h1,
        SEF_ST_RD   = 3'h3,
        SEF_ST_WR   = 3'h2,
        SEF_ST_SRD  = 3'h6,
        SEF_ST_SWR  = 3'h7,
        SEF_ST_SKIP = 3'h5
    } sef_state_e;
    typedef enum logic [2:0] {
        SEF_CMD_NONE,
        SEF_CMD_READ,
        SEF_CMD_WRITE,
        SEF_CMD_CLR_WEL,
        SEF_CMD_SET_WEL,
        SEF_CMD_SREAD,
        SEF_CMD_SWRITE
    } sef_cmd_e;
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
    } sef_pins_s;
endpackage

//--- sef_sync.sv
// Two-flop synchronisers for a group of pin inputs.
`timescale 1ns/100ps
module sef_sync #(
    parameter int unsigned W         = 4,
    parameter logic [W-1:0] RST_VAL  = '0
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset,
    // Pins in and synchronised copies out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    meta[i] <= RST_VAL[i];
                    q[i]    <= RST_VAL[i];
                end else begin
                    meta[i] <= d[i];
                    q[i]    <= meta[i];
                end
            end
        end
    endgenerate
endmodule

//--- sef_top.sv
// Serial front end and storage of a 128-byte serial EEPROM.
`timescale 1ns/100ps
`include "sef_defs.svh"
module sef_top import sef_pkg::*; #(
    parameter int unsigned WRITE_CYCLES = `EE_TWC_MS * `EE_CLK_KHZ,
    parameter int unsigned DEPTH        = `EE_DEPTH
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // Serial link inputs
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic hold_n,
    // Serial output and its enable
    output logic      so,
    output logic      so_oe,
    // Internal write cycle in progress
    output logic      write_busy
);
    localparam int unsigned TW = $clog2(WRITE_CYCLES + 1);
    localparam logic [TW-1:0] TW_LOAD = TW'(WRITE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    sef_pins_s pins;
    logic      sck_q, cs_q;

    sef_sync #(.W(4), .RST_VAL(4'h9)) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .d       ({cs_n, sck, si, hold_n}),
        .q       (pins)
    );

    // The edge detectors read only the second synchroniser stage.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sck_q <= 1'b0;
            cs_q  <= 1'b1;
        end else begin
            sck_q <= pins.sck;
            cs_q  <= pins.cs_n;
        end
    end

    logic sck_rise, sck_fall, cs_rise, active;
    assign sck_rise = pins.sck & ~sck_q;
    assign sck_fall = ~pins.sck & sck_q;
    assign cs_rise  = pins.cs_n & ~cs_q;
    assign active   = ~pins.cs_n & pins.hold_n;

    ////////////////////////////////////////////////////////////////////////////
    // opcode decode
    function automatic sef_cmd_e decode_op(input logic [7:0] b);
        logic [6:0] k;
        k = {b[7:4], b[2:0]};
        case (k)
            `EE_OP_READ:   decode_op = SEF_CMD_READ;
            `EE_OP_WRITE:  decode_op = SEF_CMD_WRITE;
            `EE_OP_CLR_WL: decode_op = SEF_CMD_CLR_WEL;
            `EE_OP_SET_WL: decode_op = SEF_CMD_SET_WEL;
            `EE_OP_SREAD:  decode_op = SEF_CMD_SREAD;
            `EE_OP_SWRITE: decode_op = SEF_CMD_SWRITE;
            default:       decode_op = SEF_CMD_NONE;
        endcase
    endfunction

    // Block protection by the two protect bits.
    function automatic logic is_protected(input logic [1:0] bp, input logic [6:0] a);
        case (bp)
            2'h1:    is_protected = (a >= `EE_PROT_QTR);
            2'h2:    is_protected = (a >= `EE_PROT_HALF);
            2'h3:    is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // storage array
    logic [7:0] mem [DEPTH];
    logic [7:0] page_buf [`EE_PAGE_BYTES];

    sef_state_e             state, next_state;
    sef_cmd_e               cmd, next_cmd;
    logic [2:0]             bit_cnt, next_bit_cnt;
    logic [7:0]             rx, next_rx, tx, next_tx;
    logic [`EE_AW-1:0]      addr, next_addr;
    logic [`EE_PAGE_BYTES-1:0] page_vld, next_page_vld;
    logic [1:0]             bp, next_bp, new_bp, next_new_bp;
    logic                   wel, next_wel, wr_ok, next_wr_ok;
    logic                   busy, next_busy, next_so, next_so_oe;
    logic [TW-1:0]          timer, next_timer;
    logic                   commit, byte_done;
    logic [7:0]             rx_byte, status;
    assign rx_byte   = {rx[6:0], pins.si};
    assign byte_done = active & sck_rise & (bit_cnt == `EE_LAST_BIT);
    assign status    = {4'h0, bp, wel, busy};

    always_comb begin
        next_state    = state;
        next_cmd      = cmd;
        next_bit_cnt  = bit_cnt;
        next_rx       = rx;
        next_tx       = tx;
        next_addr     = addr;
        next_page_vld = page_vld;
        next_bp       = bp;
        next_new_bp   = new_bp;
        next_wel      = wel;
        next_wr_ok    = wr_ok;
        next_busy     = busy;
        next_timer    = timer;
        next_so       = so;
        next_so_oe    = so_oe;
        commit        = 1'b0;
        if (busy) begin
            if (timer == '0) begin
                next_busy = 1'b0;
                next_wel  = 1'b0;
            end else begin
                next_timer = timer - TW'(1);
            end
        end
        if (cs_rise) begin
            // latch set or cleared by an instruction only if it is whole
            if (state == SEF_ST_SKIP && bit_cnt == 3'h0 && !busy) begin
                if (cmd == SEF_CMD_SET_WEL) next_wel = 1'b1;
                if (cmd == SEF_CMD_CLR_WEL) next_wel = 1'b0;
            end
            // start write only after whole data bytes
            if (wr_ok && bit_cnt == 3'h0 && wel && !busy) begin
                if (state == SEF_ST_WR) begin
                    commit     = 1'b1;
                    next_busy  = 1'b1;
                    next_timer = TW_LOAD;
                end else if (state == SEF_ST_SWR) begin
                    next_bp    = new_bp;
                    next_busy  = 1'b1;
                    next_timer = TW_LOAD;
                end
            end
        end
        if (pins.cs_n) begin
            next_state   = SEF_ST_CMD;
            next_bit_cnt = 3'h0;
            next_wr_ok   = 1'b0;
            next_so_oe   = 1'b0;
        end else if (!pins.hold_n) begin
            next_so_oe = 1'b0;
        end else begin
            next_so_oe = (state == SEF_ST_RD) || (state == SEF_ST_SRD);
            if (sck_rise) begin
                next_rx      = rx_byte;
                next_bit_cnt = bit_cnt + 3'h1;
            end
            if (sck_fall && next_so_oe) begin
                next_so = tx[7];
                next_tx = {tx[6:0], 1'b0};
            end
            if (byte_done) begin
                case (state)
                    SEF_ST_CMD: begin
                        next_cmd = decode_op(rx_byte);
                        case (decode_op(rx_byte))
                            SEF_CMD_READ, SEF_CMD_WRITE:
                                next_state = busy ? SEF_ST_SKIP : SEF_ST_ADDR;
                            SEF_CMD_SREAD: begin
                                next_state = SEF_ST_SRD;
                                next_tx    = status;
                            end
                            SEF_CMD_SWRITE: next_state = SEF_ST_SWR;
                            default:        next_state = SEF_ST_SKIP;
                        endcase
                    end
                    SEF_ST_ADDR: begin
                        next_page_vld = '0;
                        next_wr_ok    = 1'b0;
                        if (cmd == SEF_CMD_READ) begin
                            next_state = SEF_ST_RD;
                            next_tx    = mem[rx_byte[`EE_AW-1:0]];
                            next_addr  = rx_byte[`EE_AW-1:0] + `EE_AW'(1);
                        end else begin
                            next_state = SEF_ST_WR;
                            next_addr  = rx_byte[`EE_AW-1:0];
                        end
                    end
                    SEF_ST_RD: begin
                        next_tx   = mem[addr];
                        next_addr = addr + `EE_AW'(1);
                    end
                    SEF_ST_SRD: next_tx = status;
                    // page wrap on low address bits
                    SEF_ST_WR: begin
                        next_page_vld[addr[`EE_PAGE_AW-1:0]] = 1'b1;
                        next_addr[`EE_PAGE_AW-1:0] = addr[`EE_PAGE_AW-1:0] + `EE_PAGE_AW'(1);
                        next_wr_ok = 1'b1;
                    end
                    SEF_ST_SWR: begin
                        next_new_bp = rx_byte[`EE_BP_LSB+1:`EE_BP_LSB];
                        next_wr_ok  = 1'b1;
                    end
                    default: next_state = state;
                endcase
            end
        end
    end

    // pause freezes state since no edge is taken
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state    <= SEF_ST_CMD;
            cmd      <= SEF_CMD_NONE;
            bit_cnt  <= 3'h0;
            rx       <= 8'h00;
            tx       <= 8'h00;
            addr     <= '0;
            page_vld <= '0;
            bp       <= 2'h0;
            new_bp   <= 2'h0;
            wel      <= 1'b0;
            wr_ok    <= 1'b0;
            busy     <= 1'b0;
            timer    <= '0;
            so       <= 1'b0;
            so_oe    <= 1'b0;
        end else begin
            state    <= next_state;
            cmd      <= next_cmd;
            bit_cnt  <= next_bit_cnt;
            rx       <= next_rx;
            tx       <= next_tx;
            addr     <= next_addr;
            page_vld <= next_page_vld;
            bp       <= next_bp;
            new_bp   <= next_new_bp;
            wel      <= next_wel;
            wr_ok    <= next_wr_ok;
            busy     <= next_busy;
            timer    <= next_timer;
            so       <= next_so;
            so_oe    <= next_so_oe;
        end
    end
    assign write_busy = busy;

    // Storage has no reset because it models nonvolatile cells.
    always_ff @(posedge ref_clk) begin
        if (state == SEF_ST_WR && byte_done) begin
            page_buf[addr[`EE_PAGE_AW-1:0]] <= rx_byte;
        end
        if (commit) begin
            for (int i = 0; i < `EE_PAGE_BYTES; i++) begin
                if (page_vld[i] && !is_protected(bp, {addr[`EE_AW-1:`EE_PAGE_AW], 4'(i)})) begin
                    mem[{addr[`EE_AW-1:`EE_PAGE_AW], 4'(i)}] <= page_buf[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_byte_in;
        active && sck_rise && bit_cnt == `EE_LAST_BIT;
    endsequence
    sequence s_deselect;
        cs_rise ##1 (state == SEF_ST_CMD && bit_cnt == 3'h0);
    endsequence

    chk_instr_taken: assert property (s_byte_in and state == SEF_ST_CMD |=> state != SEF_ST_CMD)
        else $error("instruction byte not taken");
    chk_no_fall_sample: assert property (!sck_rise |=> rx == $past(rx))
        else $error("input sampled without rising edge");
    chk_fresh_count: assert property (pins.cs_n |=> bit_cnt == 3'h0)
        else $error("bit counter not fresh while deselected");
    chk_pause_freeze: assert property (!pins.hold_n && !pins.cs_n |=> $stable(bit_cnt) && $stable(state))
        else $error("state moved during pause");
    chk_pause_float: assert property (!pins.hold_n |=> !so_oe)
        else $error("output driven during pause");
    chk_cycle_start: assert property ($rose(busy) |-> $past(cs_rise) && $past(wel) && timer == TW_LOAD)
        else $error("write cycle started wrongly");
    chk_cycle_bound: assert property (busy |-> timer < TW'(WRITE_CYCLES))
        else $error("write cycle too long");
    chk_read_wrap: assert property (s_byte_in and state == SEF_ST_RD |=> addr == $past(addr) + `EE_AW'(1))
        else $error("read address not advanced");
    chk_latch_gate: assert property ($rose(wel) |-> $past(cs_rise) && $past(cmd) == SEF_CMD_SET_WEL)
        else $error("write latch set without enable");
    chk_page_wrap: assert property (s_byte_in and state == SEF_ST_WR |=> addr[6:4] == $past(addr[6:4]))
        else $error("page write left its page");
    chk_msb_out: assert property (active && sck_fall && next_so_oe |=> so == $past(tx[7]))
        else $error("output bit not msb of shifter");
    chk_abort: assert property (s_deselect |-> !so_oe)
        else $error("deselect did not abort");
endmodule

//--- sef_host_bfm.sv
// SPI host model that frames transfers toward the serial EEPROM front end.
`timescale 1ns/100ps
module sef_host_bfm import sef_pkg::*; #(
    parameter int unsigned HALF = 10
) (
    // Clock
    input  wire logic       ref_clk,
    // Device serial output and its enable
    input  wire logic       so,
    input  wire logic       so_oe,
    // Pins toward the device
    output sef_pins_s       pins,
    // Received byte report and output enable seen during pause
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            oe_in_pause
);
    logic last_so;

    initial begin
        pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1};
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        oe_in_pause = 1'b1;
        last_so = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // select held low from the first bit on
    task automatic begin_frame();
        tick(1);
        pins.cs_n = 1'b0;
        tick(HALF);
    endtask

    // select rises only once the last bit has been clocked
    task automatic end_frame();
        tick(HALF);
        pins.cs_n = 1'b1;
        // The data line is not listened to now, so it is not left at its last value.
        pins.si = ~pins.si;
        tick(8);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // pause mid-bit while the clock keeps toggling with garbage on the data line
    task automatic pause();
        pins.hold_n = 1'b0;
        tick(6);
        oe_in_pause = so_oe;
        repeat (2) begin
            pins.sck = 1'b1;
            pins.si = 1'($urandom);
            tick(HALF);
            pins.sck = 1'b0;
            tick(HALF);
        end
        pins.hold_n = 1'b1;
        tick(HALF);
    endtask

    // most significant bit first, in and out
    task automatic xfer(input logic [7:0] tx, input bit report, input int hold_at = -1,
                        input int bits = 8);
        logic [7:0] rx;
        rx = 8'h00;
        for (int i = 7; i > 7 - bits; i--) begin
            pins.si = tx[i];
            tick(HALF / 2);
            if (i == hold_at) begin
                pause();
            end
            tick(HALF - HALF / 2);
            // A floating output reads as the inverse of the last bit, never as a lucky match.
            rx[i] = (so_oe === 1'b1) ? so : ~last_so;
            last_so = rx[i];
            pins.sck = 1'b1;
            tick(HALF);
            pins.sck = 1'b0;
        end
        if (report) begin
            rx_byte = rx;
            rx_valid = 1'b1;
            tick(1);
            rx_valid = 1'b0;
        end
    endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the serial EEPROM front end.
`timescale 1ns/100ps
module tb_top import sef_pkg::*; ;
    localparam int unsigned WCYC = 50;

    logic       ref_clk;
    logic       reset;
    sef_pins_s  pins;
    logic       so;
    logic       so_oe;
    logic       write_busy;
    logic       rx_valid;
    logic [7:0] rx_byte;
    logic       oe_in_pause;
    logic [7:0] exp_q[$];
    logic [7:0] mem[128];
    int         n_errors = 0;
    int         compares = 0;

    sef_top #(.WRITE_CYCLES(WCYC), .DEPTH(128)) DUT (
        .ref_clk(ref_clk), .reset(reset), .sck(pins.sck), .cs_n(pins.cs_n), .si(pins.si),
        .hold_n(pins.hold_n), .so(so), .so_oe(so_oe), .write_busy(write_busy));

    sef_host_bfm #(.HALF(10)) u_host (
        .ref_clk(ref_clk), .so(so), .so_oe(so_oe), .pins(pins), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .oe_in_pause(oe_in_pause));

    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Opcode bit 3 is a don't-care, so it is randomised on every instruction except the cut-short clear-latch byte.
    function automatic logic [7:0] bit3(input logic [7:0] op);
        return op | {4'h0, 1'($urandom), 3'h0};
    endfunction

    task automatic cmd(input logic [7:0] op);
        u_host.begin_frame();
        u_host.xfer(bit3(op), 1'b0);
        u_host.end_frame();
    endtask

    task automatic status(input logic [7:0] exp);
        exp_q.push_back(exp);
        exp_q.push_back(exp);
        u_host.begin_frame();
        u_host.xfer(bit3(8'h05), 1'b0);
        u_host.xfer(8'($urandom), 1'b1);
        u_host.xfer(8'($urandom), 1'b1);
        u_host.end_frame();
    endtask

    task automatic wait_busy(input bit exp);
        int cnt;
        check({7'h00, write_busy}, {7'h00, exp});
        if (exp) begin
            // The cycle must not end early, nor run far past its length.
            repeat (WCYC - 20) @(negedge ref_clk);
            check({7'h00, write_busy}, 8'h01);
            cnt = 0;
            while (write_busy !== 1'b0 && cnt < 40) begin
                @(negedge ref_clk);
                cnt++;
            end
            check({7'h00, write_busy}, 8'h00);
        end
    endtask

    task automatic write(input logic [6:0] a, input int n, input bit latch, input int bits = 8);
        logic [7:0] d;
        if (latch) begin
            cmd(8'h06);
        end
        u_host.begin_frame();
        u_host.xfer(bit3(8'h02), 1'b0);
        u_host.xfer({1'($urandom), a}, 1'b0);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            u_host.xfer(d, 1'b0, -1, (k == n - 1) ? bits : 8);
            if (latch && bits == 8) begin
                mem[{a[6:4], 4'(a[3:0] + k)}] = d;
            end
        end
        u_host.end_frame();
        wait_busy(latch && bits == 8);
    endtask

    task automatic read(input logic [6:0] a, input int n, input int hold_at);
        u_host.begin_frame();
        u_host.xfer(bit3(8'h03), 1'b0);
        u_host.xfer({1'($urandom), a}, 1'b0);
        for (int k = 0; k < n; k++) begin
            exp_q.push_back(mem[7'(a + k)]);
            u_host.xfer(8'($urandom), 1'b1, (k == 1) ? hold_at : -1);
        end
        u_host.end_frame();
        check({7'h00, so_oe}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("MISMATCH at %0t: unexpected byte %h", $time, rx_byte);
            end else begin
                check(rx_byte, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        void'($urandom(11390));
        reset = 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        repeat (8) @(negedge ref_clk);
        check({6'h00, so_oe, write_busy}, 8'h00);
        status(8'h00);
        cmd(8'h06);
        status(8'h02);
        cmd(8'h04);
        status(8'h00);
        // A clear-latch byte cut short after five bits must not act.
        cmd(8'h06);
        u_host.begin_frame();
        u_host.xfer(8'h04, 1'b0, -1, 5);
        u_host.end_frame();
        status(8'h02);
        cmd(8'h04);
        write(7'h1C, 6, 1'b1);
        status(8'h00);
        write(7'h7E, 3, 1'b1);
        write(7'h00, 2, 1'b1);
        write(7'h10, 2, 1'b0);
        read(7'h1C, 4, -1);
        read(7'h10, 2, -1);
        read(7'h7E, 4, 3);
        check({7'h00, oe_in_pause}, 8'h00);
        // Write whose data byte is cut short: no cycle, latch stays set.
        cmd(8'h06);
        write(7'h00, 1, 1'b0, 5);
        status(8'h02);
        read(7'h00, 2, -1);
        u_host.begin_frame();
        u_host.xfer(bit3(8'h01), 1'b0);
        u_host.xfer(8'h04, 1'b0);
        u_host.end_frame();
        wait_busy(1'b1);
        status(8'h04);
        close_out();
    end
endmodule
